// ### hdl/pbm_mux.sv
// Port B alternate function mux with AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "pbm_regs.svh"

module pbm_mux
    import pbm_pkg::*;
#(
    parameter int NPINS = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire pbm_tmr_s    tmr,
    input  wire pbm_spi_s    spi,
    input  wire logic        sleep,
    input  wire logic [7:0]  pad_in,
    output var  pbm_pad_s    pad,
    output var  pbm_spi_in_s spi_in,
    output var  logic [7:0]  pin_change_source
);

    if (NPINS != 8) begin : g_bad_npins
        $error("pbm_mux serves exactly eight pins");
    end

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] dir_r;
    logic [7:0] out_r;
    logic [7:0] pcmsk_r;
    logic [7:0] pcie_r;
    logic [7:0] pins_r;
    logic       wr_r;
    logic [7:0] widx_r;
    logic       rd_go;
    logic [7:0] ridx;
    logic [7:0] rval;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ridx      = haddr[9:2];
    assign rd_go     = hsel && hready && (htrans == `PBM_HTRANS_NSQ) && !hwrite;

    // Address phase of a write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r   <= 1'b0;
            widx_r <= `PBM_RST8;
        end else if (hready) begin
            wr_r   <= hsel && (htrans == `PBM_HTRANS_NSQ) && hwrite;
            widx_r <= haddr[9:2];
        end
    end

    // Read mux, unmapped reads give zero
    always_comb begin
        unique case (ridx)
            `PBM_IDX_CTRL:  rval = ctrl_r;
            `PBM_IDX_PINS:  rval = pins_r;
            `PBM_IDX_DIR:   rval = dir_r;
            `PBM_IDX_OUT:   rval = out_r;
            `PBM_IDX_PCIE:  rval = pcie_r;
            `PBM_IDX_PCMSK: rval = pcmsk_r;
            default:        rval = `PBM_RST8;
        endcase
        // Write in its data phase reads back as it lands
        if (wr_r && (widx_r == ridx)) begin
            unique case (ridx)
                `PBM_IDX_CTRL:  rval = hwdata[7:0] & `PBM_CTRL_WMASK;
                `PBM_IDX_DIR,
                `PBM_IDX_OUT,
                `PBM_IDX_PCIE,
                `PBM_IDX_PCMSK: rval = hwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_go) begin
            hrdata <= {24'h00_0000, rval};
        end
    end

    // Register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r  <= `PBM_RST8;
            dir_r   <= `PBM_RST8;
            out_r   <= `PBM_RST8;
            pcmsk_r <= `PBM_RST8;
            pcie_r  <= `PBM_RST8;
        end else if (wr_r) begin
            unique case (widx_r)
                `PBM_IDX_CTRL:  ctrl_r  <= hwdata[7:0] & `PBM_CTRL_WMASK;
                `PBM_IDX_DIR:   dir_r   <= hwdata[7:0];
                `PBM_IDX_OUT:   out_r   <= hwdata[7:0];
                `PBM_IDX_PCIE:  pcie_r  <= hwdata[7:0];
                `PBM_IDX_PCMSK: pcmsk_r <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pad input synchronisers
    // ------------------------------------------------------------
    logic [7:0] s1_r;
    logic [7:0] s2_r;
    logic [7:0] s3_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= `PBM_RST8;
            s2_r <= `PBM_RST8;
            s3_r <= `PBM_RST8;
        end else begin
            s1_r <= pad_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_r <= `PBM_RST8;
        end else begin
            pins_r <= (s2_r & s3_r) | (pins_r & (s2_r ^ s3_r));
        end
    end

    // ------------------------------------------------------------
    // Override signals per pin
    // ------------------------------------------------------------
    logic       global_pullup_disable;
    logic       sp_mst;
    logic       sp_slv;
    logic [7:0] pullup_override_enable;
    logic [7:0] pullup_override_value;
    logic [7:0] direction_override_enable;
    logic [7:0] direction_override_value;
    logic [7:0] port_value_override_enable;
    logic [7:0] port_value_override_value;
    logic [7:0] input_enable_override_enable;
    logic [7:0] oe_nxt;
    logic [7:0] out_nxt;
    logic [7:0] pu_nxt;
    logic [7:0] die_nxt;

    assign global_pullup_disable    = ctrl_r[`PBM_CTRL_PUD];
    assign sp_mst = spi.serial_periph_enable && spi.serial_master_select;
    assign sp_slv = spi.serial_periph_enable && !spi.serial_master_select;

    always_comb begin
        pullup_override_enable  = `PBM_RST8;
        pullup_override_value  = `PBM_RST8;
        direction_override_enable  = `PBM_RST8;
        direction_override_value  = `PBM_RST8;
        port_value_override_enable  = `PBM_RST8;
        port_value_override_value  = `PBM_RST8;
        // Timer compare outputs on pins 4 to 7
        port_value_override_enable[7:`PBM_TMR_LO] = tmr.en;
        port_value_override_value[7:`PBM_TMR_LO] = tmr.val;
        // SPI forced inputs
        direction_override_enable[`PBM_PIN_MISO] = sp_mst;
        direction_override_enable[`PBM_PIN_MOSI] = sp_slv;
        direction_override_enable[`PBM_PIN_SCK]  = sp_slv;
        direction_override_enable[`PBM_PIN_SS]   = sp_slv;
        pullup_override_enable[3:0] = direction_override_enable[3:0];
        pullup_override_value[3:0] = out_r[3:0] & {4{!global_pullup_disable}};
        // SPI driven values, never on slave select
        port_value_override_enable[`PBM_PIN_MISO] = sp_slv;
        port_value_override_value[`PBM_PIN_MISO] = spi.slave_out;
        port_value_override_enable[`PBM_PIN_MOSI] = sp_mst;
        port_value_override_value[`PBM_PIN_MOSI] = spi.serial_master_select_out;
        port_value_override_enable[`PBM_PIN_SCK]  = sp_mst;
        port_value_override_value[`PBM_PIN_SCK]  = spi.sck_out;
    end

    assign input_enable_override_enable = pcmsk_r & {8{pcie_r[`PBM_PCIE_G1]}};

    // Generic pin control, one copy per pin
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        assign oe_nxt[i]  = direction_override_enable[i] ? direction_override_value[i] : dir_r[i];
        assign out_nxt[i] = (port_value_override_enable[i] && oe_nxt[i]) ? port_value_override_value[i] : out_r[i];
        assign pu_nxt[i]  = pullup_override_enable[i] ? pullup_override_value[i]
                          : ({dir_r[i], out_r[i], global_pullup_disable} == 3'b010);
        assign die_nxt[i] = input_enable_override_enable[i] ? 1'b1 : !sleep;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad <= '0;
        end else begin
            pad.out <= out_nxt;
            pad.oe  <= oe_nxt;
            pad.pu  <= pu_nxt;
            pad.die <= die_nxt;
        end
    end

    // Inputs to the alternate functions, before any synchroniser
    assign pin_change_source = pad_in;
    assign spi_in.serial_master_select_in    = pad_in[`PBM_PIN_MISO];
    assign spi_in.slave_in   = pad_in[`PBM_PIN_MOSI];
    assign spi_in.sck_in     = pad_in[`PBM_PIN_SCK];
    assign spi_in.ss_n       = pad_in[`PBM_PIN_SS];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_pud_off;
        global_pullup_disable |=> (pad.pu == 8'h00);
    endproperty
    a_pud_off: assert property (p_pud_off)
        else $error("pull-up on while disabled");

    property p_timer2_compare_a_out;
        (tmr.en[3] && dir_r[7]) |=> (pad.out[7] == $past(tmr.val[3]));
    endproperty
    a_timer2_compare_a_out: assert property (p_timer2_compare_a_out)
        else $error("pin 7 lost compare output");

    property p_timer1_compare_b_out;
        (tmr.en[2] && dir_r[6]) |=> (pad.out[6] == $past(tmr.val[2])) && pad.oe[6];
    endproperty
    a_timer1_compare_b_out: assert property (p_timer1_compare_b_out)
        else $error("pin 6 lost compare output");

    property p_timer1_compare_a_out;
        (!tmr.en[1] && dir_r[5]) |=> (pad.out[5] == $past(out_r[5]));
    endproperty
    a_timer1_compare_a_out: assert property (p_timer1_compare_a_out)
        else $error("pin 5 overridden while disabled");

    property p_timer0_compare_a_out;
        (tmr.en[0] && dir_r[4]) ##1 (tmr.en[0] && dir_r[4])
            |=> (pad.out[4] == $past(tmr.val[0]));
    endproperty
    a_timer0_compare_a_out: assert property (p_timer0_compare_a_out)
        else $error("pin 4 lost compare output");

    property p_miso;
        sp_mst |=> !pad.oe[`PBM_PIN_MISO]
            && (pad.pu[`PBM_PIN_MISO] == $past(out_r[`PBM_PIN_MISO] && !global_pullup_disable));
    endproperty
    a_miso: assert property (p_miso)
        else $error("miso not forced input");

    property p_mosi;
        sp_slv |=> !pad.oe[`PBM_PIN_MOSI];
    endproperty
    a_mosi: assert property (p_mosi)
        else $error("mosi not forced input");

    property p_sck;
        sp_mst |=> (pad.oe[`PBM_PIN_SCK] == $past(dir_r[`PBM_PIN_SCK]));
    endproperty
    a_sck: assert property (p_sck)
        else $error("sck direction wrong as master");

    property p_ss;
        !sp_slv |=> (pad.oe[`PBM_PIN_SS] == $past(dir_r[`PBM_PIN_SS]))
            && (pad.out[`PBM_PIN_SS] == $past(out_r[`PBM_PIN_SS]));
    endproperty
    a_ss: assert property (p_ss)
        else $error("slave select overridden");

    property p_forced_pu;
        sp_slv |=> (pad.pu[2:0] == $past(out_r[2:0] & {3{!global_pullup_disable}}));
    endproperty
    a_forced_pu: assert property (p_forced_pu)
        else $error("forced input pull-up wrong");

    property p_die;
        (pcie_r[`PBM_PCIE_G1] && sleep) |=> (pad.die == $past(pcmsk_r));
    endproperty
    a_die: assert property (p_die)
        else $error("input enable override wrong in sleep");

    property p_plain_pu;
        (!spi.serial_periph_enable && !global_pullup_disable) |=> (pad.pu == $past(out_r & ~dir_r));
    endproperty
    a_plain_pu: assert property (p_plain_pu)
        else $error("plain pull-up wrong");

    property p_timer1_compare_a_out_on;
        (tmr.en[1] && dir_r[5]) |=> (pad.out[5] == $past(tmr.val[1])) && pad.oe[5];
    endproperty
    a_timer1_compare_a_out_on: assert property (p_timer1_compare_a_out_on)
        else $error("pin 5 lost compare output");

    property p_miso_out;
        (sp_slv && dir_r[`PBM_PIN_MISO]) |=> pad.oe[`PBM_PIN_MISO]
            && (pad.out[`PBM_PIN_MISO] == $past(spi.slave_out));
    endproperty
    a_miso_out: assert property (p_miso_out)
        else $error("miso slave output wrong");

    property p_mosi_out;
        (sp_mst && dir_r[`PBM_PIN_MOSI]) |=> (pad.out[`PBM_PIN_MOSI] == $past(spi.serial_master_select_out));
    endproperty
    a_mosi_out: assert property (p_mosi_out)
        else $error("mosi master output wrong");

    property p_sck_out;
        (sp_mst && dir_r[`PBM_PIN_SCK]) |=> (pad.out[`PBM_PIN_SCK] == $past(spi.sck_out));
    endproperty
    a_sck_out: assert property (p_sck_out)
        else $error("sck master output wrong");

    property p_plain_val;
        (!spi.serial_periph_enable && (tmr.en == 4'h0)) |=> (pad.out == $past(out_r));
    endproperty
    a_plain_val: assert property (p_plain_val)
        else $error("port value overridden without enable");

    property p_plain_dir;
        !spi.serial_periph_enable |=> (pad.oe == $past(dir_r));
    endproperty
    a_plain_dir: assert property (p_plain_dir)
        else $error("driver enable not from dir bit");

    property p_die_awake;
        !sleep |=> (pad.die == 8'hff);
    endproperty
    a_die_awake: assert property (p_die_awake)
        else $error("input disabled while awake");

endmodule : pbm_mux
`default_nettype wire

// ### hdl/pbm_regs.svh
// Register map and field constants for the port B pin mux
`ifndef PBM_REGS_SVH
`define PBM_REGS_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define PBM_IDX_CTRL   8'h35
`define PBM_IDX_PINS   8'h23
`define PBM_IDX_DIR    8'h24
`define PBM_IDX_OUT    8'h25
`define PBM_IDX_PCIE   8'h3d
`define PBM_IDX_PCMSK  8'h6c

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PBM_CTRL_DBG   7
`define PBM_CTRL_PUD   4
`define PBM_CTRL_IVS   1
`define PBM_CTRL_IVC   0
`define PBM_CTRL_WMASK 8'h93
`define PBM_PCIE_G1    1
`define PBM_RST8       8'h00
`define PBM_PIN_MISO   3
`define PBM_PIN_MOSI   2
`define PBM_PIN_SCK    1
`define PBM_PIN_SS     0
`define PBM_TMR_LO     4
`define PBM_HTRANS_NSQ 2'b10

`endif

// ### hdl/pbm_pkg.sv
// Types shared by the port B pin mux
package pbm_pkg;

    // Compare outputs, index 0 is pin 4 up to index 3 at pin 7
    typedef struct packed {
        logic [3:0] en;
        logic [3:0] val;
    } pbm_tmr_s;

    // SPI unit side of the mux
    typedef struct packed {
        logic serial_periph_enable;
        logic serial_master_select;
        logic slave_out;
        logic serial_master_select_out;
        logic sck_out;
    } pbm_spi_s;

    // Inputs routed back to the SPI unit
    typedef struct packed {
        logic serial_master_select_in;
        logic slave_in;
        logic sck_in;
        logic ss_n;
    } pbm_spi_in_s;

    // Pad controls for the eight pins
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
        logic [7:0] die;
    } pbm_pad_s;

endpackage : pbm_pkg

// ### tb/pbm_far_model.sv
// Far-side model: timers, SPI unit and pads
`timescale 1ns/1ns
`default_nettype none
module pbm_far_model
    import pbm_pkg::*;
(
    input  wire logic       hclk,
    input  wire pbm_tmr_s   tmr_req,
    input  wire pbm_spi_s   spi_req,
    input  wire logic [7:0] ext,
    input  wire pbm_pad_s   pad,
    output var  pbm_tmr_s   tmr,
    output var  pbm_spi_s   spi,
    output var  logic [7:0] pad_in
);
    // Peripherals change just after a clock edge
    always_ff @(posedge hclk) begin
        tmr <= tmr_req;
        spi <= spi_req;
    end
    // Pad level: own driver, else pull-up, else outside level
    assign pad_in = (pad.oe & pad.out) | (~pad.oe & (pad.pu | ext));
endmodule : pbm_far_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the port B pin mux
`timescale 1ns/1ns
`default_nettype none
`include "pbm_regs.svh"
module testbench
    import pbm_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hready, hresp, sleep, pud_v, g1_v;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [7:0]  ext, pin_change_source, pad_in, dir_v, out_v, msk_v;
    pbm_tmr_s    tmr_v, tmr;
    pbm_spi_s    spi_v, spi;
    pbm_pad_s    pad;
    pbm_spi_in_s spi_in;
    int          error_cnt, n_tests, cyc;

    pbm_mux pbm_mux_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .tmr(tmr), .spi(spi), .sleep(sleep),
        .pad_in(pad_in), .pad(pad), .spi_in(spi_in), .pin_change_source(pin_change_source));
    pbm_far_model pbm_far_model_i (.hclk(hclk), .tmr_req(tmr_v), .spi_req(spi_v), .ext(ext),
        .pad(pad), .tmr(tmr), .spi(spi), .pad_in(pad_in));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    task automatic end_sim();
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= `PBM_HTRANS_NSQ;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : xfer

    task automatic cfg(input logic [7:0] d, input logic [7:0] o, input logic p);
        dir_v = d;
        out_v = o;
        pud_v = p;
        xfer(1'b1, `PBM_IDX_DIR, d);
        xfer(1'b1, `PBM_IDX_OUT, o);
        xfer(1'b1, `PBM_IDX_CTRL, {3'h0, p, 4'h0});
    endtask : cfg

    task automatic drv(input pbm_tmr_s t, input pbm_spi_s s, input logic sl);
        @(posedge hclk);
        tmr_v <= t;
        spi_v <= s;
        sleep <= sl;
    endtask : drv

    function automatic pbm_pad_s exp_pad();
        pbm_pad_s   e;
        logic       ms;
        logic       sl;
        ms = spi_v.serial_periph_enable & spi_v.serial_master_select;
        sl = spi_v.serial_periph_enable & ~spi_v.serial_master_select;
        e.oe = dir_v & ~{4'h0, ms, {3{sl}}};
        e.pu = ~e.oe & out_v & {8{~pud_v}};
        e.out = out_v;
        e.out[7:4] = (tmr_v.en & tmr_v.val) | (~tmr_v.en & out_v[7:4]);
        if (ms) e.out[2:1] = {spi_v.serial_master_select_out, spi_v.sck_out};
        if (sl) e.out[3] = spi_v.slave_out;
        e.out = e.out & e.oe;
        e.die = (msk_v & {8{g1_v}}) | {8{~sleep}};
        return e;
    endfunction : exp_pad

    task automatic cpad();
        repeat (3) @(posedge hclk);
        #1;
        chk({pad.out & pad.oe, pad.oe, pad.pu, pad.die}, exp_pad());
    endtask : cpad

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_regs();
        xfer(1'b1, `PBM_IDX_CTRL, 8'hff);
        xfer(1'b0, `PBM_IDX_CTRL, 8'h00);
        chk(q, 32'h93);
        xfer(1'b1, `PBM_IDX_CTRL, 8'h00);
        xfer(1'b0, 8'h00, 8'h00);
        chk(q, 32'h0);
    endtask : t_regs

    task automatic t_pull();
        cfg(8'h0f, 8'hff, 1'b0);
        cpad();
        cfg(8'h0f, 8'hff, 1'b1);
        cpad();
    endtask : t_pull

    task automatic t_tmr();
        drv(8'h5a, 5'h00, 1'b0);
        cfg(8'hf0, 8'h50, 1'b0);
        cpad();
        drv(8'hf5, 5'h00, 1'b0);
        cpad();
        cfg(8'h00, 8'h50, 1'b0);
        cpad();
    endtask : t_tmr

    task automatic t_spi();
        for (int m = 0; m < 4; m++) begin
            drv(8'h00, {m[1], m[0], 3'b011}, 1'b0);
            cfg(8'h0f, 8'h09, 1'b0);
            cpad();
            chk({28'h0, spi_in}, {28'h0, pad_in[3:0]});
            chk({24'h0, pin_change_source}, {24'h0, pad_in});
        end
        // Pin status register after the levels have settled
        xfer(1'b0, `PBM_IDX_PINS, 8'h00);
        chk(q, {24'h0, pad_in});
    endtask : t_spi

    task automatic t_pcint();
        drv(8'h00, 5'h00, 1'b1);
        msk_v = 8'h81;
        g1_v = 1'b1;
        xfer(1'b1, `PBM_IDX_PCMSK, 8'h81);
        xfer(1'b1, `PBM_IDX_PCIE, 8'h02);
        cpad();
        g1_v = 1'b0;
        xfer(1'b1, `PBM_IDX_PCIE, 8'h00);
        cpad();
    endtask : t_pcint

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        sleep = 1'b0;
        ext = 8'h3c;
        tmr_v = '0;
        spi_v = '0;
        {dir_v, out_v, msk_v, pud_v, g1_v} = '0;
        error_cnt = 0;
        n_tests = 0;
        cyc = 0;
        repeat (2) @(posedge hclk);
        #1;
        chk(pad, 32'h0);
        chk(hrdata, 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, `PBM_IDX_CTRL, 8'h00);
        chk(q, 32'h0);
        cpad();
        t_regs();
        t_pull();
        t_tmr();
        t_spi();
        t_pcint();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
